//--- rtl/fma_far_alu.sv
// Datapath for far move, OR and rotate instructions on a data-memory byte.
//
// Contract
// - Move to accumulator loads the memory byte, flags untouched.
// - Move to memory writes the accumulator into the byte, flags untouched.
// - OR to accumulator stores ACC OR byte in ACC, updates zero only.
// - OR to memory writes ACC OR byte back, updates zero, ACC kept.
// - Plain left rotate in memory, bit 7 into bit 0, no flag change.
// - Plain left rotate result to accumulator, memory and flags unchanged.
// - Left rotate through carry in memory; old carry to bit 0, bit 7 to carry.
// - Left rotate through carry to accumulator; carry from bit 7, memory kept.
// - Plain right rotate in memory, bit 0 into bit 7, no flag change.
// - Plain right rotate result to accumulator, memory and flags unchanged.
// - Right rotate through carry; old carry to bit 7, bit 0 to carry.
module fma_far_alu
  import fma_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire fma_req_t             req,
  input  wire logic [FMA_DW-1:0]    mem_rdata,
  output logic                      busy,
  output logic                      mem_re,
  output logic [FMA_AW-1:0]         mem_raddr,
  output fma_mem_wr_t               mem_wr,
  output logic [FMA_DW-1:0]         acc,
  output logic                      flag_z,
  output logic                      flag_c,
  output logic                      done
);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Two phases: read the byte, then compute and commit. New requests are
  // ignored while busy, so no other access can split a read-modify-write.
  typedef enum logic [1:0] {
    FMA_ST_IDLE = 2'b01,
    FMA_ST_EXEC = 2'b10
  } fma_state_t;

  fma_state_t           state_q, state_d;
  fma_op_t              op_q;
  logic [FMA_AW-1:0]    addr_q;
  logic [FMA_DW-1:0]    acc_q, acc_d;
  logic                 z_q, z_d, c_q, c_d;
  logic                 busy_q, re_q, done_q;
  fma_mem_wr_t          wr_q, wr_d;

  function automatic logic [FMA_DW-1:0] rotl(input logic [FMA_DW-1:0] v, input logic in);
    rotl = {v[FMA_TOP_BIT-1:0], in};
  endfunction

  function automatic logic [FMA_DW-1:0] rotr(input logic [FMA_DW-1:0] v, input logic in);
    rotr = {in, v[FMA_TOP_BIT:1]};
  endfunction

  // ****************************************************************
  // Result selection
  // ****************************************************************
  wire logic                 take    = req.valid && (state_q == FMA_ST_IDLE);
  wire logic                 exec    = (state_q == FMA_ST_EXEC);
  wire logic [FMA_DW-1:0]    or_res  = acc_q | mem_rdata;
  wire logic                 top_in  = mem_rdata[FMA_TOP_BIT];
  wire logic                 bot_in  = mem_rdata[FMA_BOT_BIT];
  wire logic [FMA_DW-1:0]    rl_res  = rotl(mem_rdata, top_in);
  wire logic [FMA_DW-1:0]    rlc_res = rotl(mem_rdata, c_q);
  wire logic [FMA_DW-1:0]    rr_res  = rotr(mem_rdata, bot_in);
  wire logic [FMA_DW-1:0]    rrc_res = rotr(mem_rdata, c_q);

  always_comb begin
    acc_d      = acc_q;
    z_d        = z_q;
    c_d        = c_q;
    wr_d.we    = 1'b0;
    wr_d.addr  = addr_q;
    wr_d.wdata = wr_q.wdata;
    state_d    = state_q;
    unique case (state_q)
      FMA_ST_IDLE: begin
        if (take) begin
          state_d = FMA_ST_EXEC;
        end
      end
      FMA_ST_EXEC: begin
        state_d = FMA_ST_IDLE;
        unique case (op_q)
          FMA_OP_MOVE_TO_ACC: acc_d = mem_rdata;
          FMA_OP_MOVE_TO_MEM: begin
            wr_d.we    = 1'b1;
            wr_d.wdata = acc_q;
          end
          FMA_OP_OR_TO_ACC: begin
            acc_d = or_res;
            z_d   = (or_res == 8'h00);
          end
          FMA_OP_OR_TO_MEM: begin
            wr_d.we    = 1'b1;
            wr_d.wdata = or_res;
            z_d        = (or_res == 8'h00);
          end
          FMA_OP_ROTL: begin
            wr_d.we    = 1'b1;
            wr_d.wdata = rl_res;
          end
          FMA_OP_ROTL_TO_ACC: acc_d = rl_res;
          FMA_OP_ROTL_THRU_C: begin
            wr_d.we    = 1'b1;
            wr_d.wdata = rlc_res;
            c_d        = top_in;
          end
          FMA_OP_ROTL_THRU_C_ACC: begin
            acc_d = rlc_res;
            c_d   = top_in;
          end
          FMA_OP_ROTR: begin
            wr_d.we    = 1'b1;
            wr_d.wdata = rr_res;
          end
          FMA_OP_ROTR_TO_ACC: acc_d = rr_res;
          FMA_OP_ROTR_THRU_C: begin
            wr_d.we    = 1'b1;
            wr_d.wdata = rrc_res;
            c_d        = bot_in;
          end
          FMA_OP_ROTR_THRU_C_ACC: begin
            acc_d = rrc_res;
            c_d   = bot_in;
          end
          default: acc_d = acc_q;
        endcase
      end
      default: state_d = FMA_ST_IDLE;
    endcase
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= FMA_ST_IDLE;
      op_q    <= FMA_OP_NONE;
      addr_q  <= '0;
      acc_q   <= FMA_ACC_RST;
      z_q     <= FMA_FLG_RST;
      c_q     <= FMA_FLG_RST;
      wr_q    <= '0;
      busy_q  <= 1'b0;
      re_q    <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) begin
        op_q   <= req.op;
        addr_q <= req.addr;
      end
      acc_q  <= acc_d;
      z_q    <= z_d;
      c_q    <= c_d;
      wr_q   <= wr_d;
      busy_q <= take;
      re_q   <= take;
      done_q <= exec;
    end
  end

  assign busy      = busy_q;
  assign mem_re    = re_q;
  assign mem_raddr = addr_q;
  assign mem_wr    = wr_q;
  assign acc       = acc_q;
  assign flag_z    = z_q;
  assign flag_c    = c_q;
  assign done      = done_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_move_acc_load: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_MOVE_TO_ACC |=> acc == $past(mem_rdata) && $stable(flag_z)
      && $stable(flag_c) && !mem_wr.we) else $error("move to acc wrong");
  a_move_mem_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_MOVE_TO_MEM |=> mem_wr.we && mem_wr.wdata == $past(acc)
      && $stable(acc) && $stable(flag_c)) else $error("move to mem wrong");
  a_or_acc_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_OR_TO_ACC |=> acc == ($past(acc) | $past(mem_rdata))
      && flag_z == (acc == 8'h00) && $stable(flag_c)) else $error("or to acc wrong");
  a_or_mem_keep: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_OR_TO_MEM |=> mem_wr.we && $stable(acc) && $stable(flag_c)
      && mem_wr.wdata == ($past(acc) | $past(mem_rdata))
      && flag_z == (mem_wr.wdata == 8'h00)) else $error("or to mem wrong");
  a_rotl_mem: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_ROTL |=> mem_wr.we && $stable(flag_c)
      && mem_wr.wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}) else $error("rotl bad");
  a_rotl_acc: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_ROTL_TO_ACC |=> !mem_wr.we
      && acc == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}) else $error("rotl acc bad");
  a_rotlc_mem: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_ROTL_THRU_C |=> mem_wr.we && flag_c == $past(mem_rdata[7])
      && mem_wr.wdata == {$past(mem_rdata[6:0]), $past(flag_c)}) else $error("rotlc bad");
  a_rotlc_acc: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_ROTL_THRU_C_ACC |=> !mem_wr.we && flag_c == $past(mem_rdata[7])
      && acc == {$past(mem_rdata[6:0]), $past(flag_c)}) else $error("rotlc acc bad");
  a_rotr_mem: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_ROTR |=> mem_wr.we && $stable(flag_z)
      && mem_wr.wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}) else $error("rotr bad");
  a_rotr_acc: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_ROTR_TO_ACC |=> !mem_wr.we
      && acc == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}) else $error("rotr acc bad");
  a_rotrc_mem: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_ROTR_THRU_C |=> mem_wr.we && flag_c == $past(mem_rdata[0])
      && mem_wr.wdata == {$past(flag_c), $past(mem_rdata[7:1])}) else $error("rotrc bad");
  a_rotrc_acc: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec && op_q == FMA_OP_ROTR_THRU_C_ACC |=> !mem_wr.we && flag_c == $past(mem_rdata[0])
      && acc == {$past(flag_c), $past(mem_rdata[7:1])}) else $error("rotrc acc bad");
  a_rmw_atomic: assert property (@(posedge core_clk) disable iff (!arst_n)
    take |=> busy ##1 (!busy && done && mem_wr.addr == $past(mem_raddr)))
    else $error("rmw not atomic");

endmodule

//--- shared/fma_pkg.sv
// Package of opcodes, field layouts and reset values for the far move/OR/rotate datapath.
package fma_pkg;

  // ****************************************************************
  // Operation codes presented by the decoder
  // ****************************************************************
  typedef enum logic [3:0] {
    FMA_OP_NONE              = 4'h0,
    FMA_OP_MOVE_TO_ACC       = 4'h1,
    FMA_OP_MOVE_TO_MEM       = 4'h2,
    FMA_OP_OR_TO_ACC         = 4'h3,
    FMA_OP_OR_TO_MEM         = 4'h4,
    FMA_OP_ROTL              = 4'h5,
    FMA_OP_ROTL_TO_ACC       = 4'h6,
    FMA_OP_ROTL_THRU_C       = 4'h7,
    FMA_OP_ROTL_THRU_C_ACC   = 4'h8,
    FMA_OP_ROTR              = 4'h9,
    FMA_OP_ROTR_TO_ACC       = 4'hA,
    FMA_OP_ROTR_THRU_C       = 4'hB,
    FMA_OP_ROTR_THRU_C_ACC   = 4'hC
  } fma_op_t;

  // ****************************************************************
  // Widths, bit positions and reset values
  // ****************************************************************
  localparam int unsigned FMA_DW      = 8;
  localparam int unsigned FMA_AW      = 16;
  localparam int unsigned FMA_TOP_BIT = 7;
  localparam int unsigned FMA_BOT_BIT = 0;
  localparam logic [7:0]  FMA_ACC_RST = 8'h00;
  localparam logic        FMA_FLG_RST = 1'b0;

  // ****************************************************************
  // Request from the decoder and answer toward memory and core
  // ****************************************************************
  typedef struct packed {
    logic                valid;
    fma_op_t             op;
    logic [FMA_AW-1:0]   addr;
  } fma_req_t;

  typedef struct packed {
    logic                we;
    logic [FMA_AW-1:0]   addr;
    logic [FMA_DW-1:0]   wdata;
  } fma_mem_wr_t;

endpackage

//--- dv/fma_mem_model.sv
// Behavioural data memory that answers the far datapath.
module fma_mem_model
  import fma_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              mem_re,
  input  wire logic [FMA_AW-1:0] mem_raddr,
  input  wire fma_mem_wr_t       mem_wr,
  output logic [FMA_DW-1:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Storage and read port
  // ****************************************
  logic [FMA_DW-1:0] mem [16];
  logic [FMA_DW-1:0] last_q = 8'h00;

  // Outside a read the bus shows the inverse of the last byte, so stale data is never reused.
  assign mem_rdata = mem_re ? mem[mem_raddr[3:0]] : ~last_q;

  always @(posedge core_clk) begin
    if (mem_re) last_q <= mem[mem_raddr[3:0]];
    if (mem_wr.we) mem[mem_wr.addr[3:0]] <= mem_wr.wdata;
  end
endmodule

//--- dv/fma_far_alu_test.sv
// Self-checking testbench for the far move, OR and rotate datapath.
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("Error at %0t ns: got %0h expected %0h", $time, (got), (exp)); \
  end \
end

module fma_far_alu_test
  import fma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Signals and instances
  // ****************************************
  logic              core_clk    = 1'b0;
  logic              arst_n      = 1'b0;
  fma_req_t          req         = '0;
  logic [FMA_DW-1:0] mem_rdata;
  logic              busy;
  logic              mem_re;
  logic [FMA_AW-1:0] mem_raddr;
  fma_mem_wr_t       mem_wr;
  logic [FMA_DW-1:0] acc;
  logic              flag_z;
  logic              flag_c;
  logic              done;
  logic [9:0]        st;
  int                bad_count   = 0;
  int                check_count = 0;

  assign st = {acc, flag_z, flag_c};
  always #25 core_clk = ~core_clk;

  fma_far_alu dut (.core_clk(core_clk), .arst_n(arst_n), .req(req), .mem_rdata(mem_rdata),
    .busy(busy), .mem_re(mem_re), .mem_raddr(mem_raddr), .mem_wr(mem_wr), .acc(acc),
    .flag_z(flag_z), .flag_c(flag_c), .done(done));

  fma_mem_model u_mem (.core_clk(core_clk), .mem_re(mem_re), .mem_raddr(mem_raddr),
    .mem_wr(mem_wr), .mem_rdata(mem_rdata));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic final_report();
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Holding valid for three edges makes the block take the request twice.
  task automatic run(input fma_op_t op, input logic [3:0] a, input logic [7:0] d,
                     input int hold);
    int n;
    int got;
    u_mem.mem[a] = d;
    req = '{1'b1, op, {12'h000, a}};
    n = 0;
    got = 0;
    // Done pulses are counted until one per take is seen, also after valid drops, so none is missed.
    while (n < hold || got < (hold + 1) / 2) begin
      if (n == hold + 8) begin
        bad_count++;
        final_report();
      end
      @(posedge core_clk);
      #1 n++;
      if (n == hold) req.valid = 1'b0;
      if (n == 1) `CHK({busy, mem_re, mem_raddr}, {2'b11, 12'h000, a})
      if (n == 2) `CHK({busy, done}, 2'b01)
      if (done === 1'b1) got++;
    end
    @(posedge core_clk);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_carry();
    run(FMA_OP_ROTL_THRU_C, 4'h8, 8'h80, 1);
    `CHK({u_mem.mem[8], st}, {8'h00, 10'h001})
    run(FMA_OP_ROTL_THRU_C_ACC, 4'h9, 8'h40, 1);
    `CHK({u_mem.mem[9], st}, {8'h40, 8'h81, 2'b00})
    run(FMA_OP_ROTR_THRU_C, 4'hA, 8'h01, 1);
    `CHK({u_mem.mem[10], st}, {8'h00, 8'h81, 2'b01})
    run(FMA_OP_ROTR_THRU_C_ACC, 4'hB, 8'h04, 1);
    `CHK({u_mem.mem[11], st}, {8'h04, 8'h82, 2'b00})
    run(FMA_OP_ROTL_THRU_C, 4'hC, 8'hFF, 1);
    `CHK({u_mem.mem[12], st}, {8'hFE, 8'h82, 2'b01})
  endtask

  task automatic t_move_or();
    run(FMA_OP_MOVE_TO_ACC, 4'h1, 8'hA5, 1);
    `CHK(st, {8'hA5, 2'b01})
    run(FMA_OP_MOVE_TO_MEM, 4'h2, 8'h3C, 1);
    `CHK({u_mem.mem[2], st}, {8'hA5, 8'hA5, 2'b01})
    run(FMA_OP_MOVE_TO_ACC, 4'h4, 8'h00, 1);
    run(FMA_OP_OR_TO_ACC, 4'h3, 8'h00, 1);
    `CHK(st, {8'h00, 2'b11})
    run(FMA_OP_MOVE_TO_ACC, 4'h1, 8'hA5, 1);
    `CHK(st, {8'hA5, 2'b11})
    run(FMA_OP_OR_TO_MEM, 4'h5, 8'h5A, 1);
    `CHK({u_mem.mem[5], st}, {8'hFF, 8'hA5, 2'b01})
  endtask

  task automatic t_plain();
    run(FMA_OP_ROTL, 4'h6, 8'h81, 1);
    `CHK({u_mem.mem[6], st}, {8'h03, 8'hA5, 2'b01})
    run(FMA_OP_ROTL_TO_ACC, 4'h6, 8'h03, 1);
    `CHK({u_mem.mem[6], st}, {8'h03, 8'h06, 2'b01})
    run(FMA_OP_ROTR, 4'h7, 8'h01, 1);
    `CHK({u_mem.mem[7], st}, {8'h80, 8'h06, 2'b01})
    run(FMA_OP_ROTR_TO_ACC, 4'h7, 8'h80, 1);
    `CHK({u_mem.mem[7], st}, {8'h80, 8'h40, 2'b01})
  endtask

  // The second take must read the byte the first one wrote back.
  task automatic t_back_to_back();
    run(FMA_OP_ROTL, 4'hD, 8'h11, 3);
    `CHK({u_mem.mem[13], st}, {8'h44, 8'h40, 2'b01})
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    #1 arst_n = 1'b1;
    t_carry();
    t_move_or();
    t_plain();
    t_back_to_back();
    final_report();
  end
endmodule
